/* scsi_sideband_defines.vh */
`ifndef SCSI_SIDEBAND_DEFINES_VH
`define SCSI_SIDEBAND_DEFINES_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_BLOCK_CONTROL 5'h00
`define OFS_DEVICE_CONFIG 5'h04
`define OFS_XFER_CONTROL_ONE 5'h08
`define OFS_BUS_CONTROL 5'h0C
`define OFS_BUS_STATUS 5'h10
`define OFS_DIFF_CONTROL 5'h14

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BC_LED_DIAG_EN 0
`define BC_LED_DIAG_VAL 1
`define BC_RUN_LED_CLR 2
`define BC_WIDE_CABLE 3
`define BC_RUN_LED 4
`define DC_TERM_POLARITY 0
`define DC_MEM_SINGLE 1
`define DC_SOFT_RESET 15
`define DC_ID_LSB 8
`define XC_TERM_ON 0
`define CT_TARGET 0
`define CT_ARB 1
`define CT_WON 2
`define CT_ATN 3
`define CT_BUS_RST 4
`define CT_CD 5
`define CT_IO 6
`define CT_MSG 7
`define CT_REQ 8
`define CT_ACK 9
`define ST_RESET_SEEN 9
`define ST_ACTIVITY 10
`define ST_ID_SHIFT 11
`define DF_SEL_LSB 4
`define DF_BUSY 8

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_DEFAULT_ID 4'h7
`define RST_CONTROL 10'h000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CORE_CLK_HZ 200000000
`define ID_CLK_HZ 20000000
`define ID_HALF_CYC (`CORE_CLK_HZ / (2 * `ID_CLK_HZ))
`define STROBE_NS 50
`define STROBE_CYC ((`STROBE_NS * (`CORE_CLK_HZ / 1000000) + 999) / 1000)
`define RAM_SAMPLE_EDGE 4'h4

`endif

/* scsi_bus_sideband_pin_control.v */
`timescale 1ns/1ps
`default_nettype none
`include "scsi_sideband_defines.vh"

module scsi_bus_sideband_pin_control #(
	parameter ID_BITS = 4,
	parameter ID_HALF = `ID_HALF_CYC,
	parameter STROBE_CYCLES = `STROBE_CYC
) (
	input wire core_clk,
	input wire rst_b,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire selection_in_progress,
	input wire selected_in_flag,
	input wire selection_out_done,
	output reg scsi_reset_clear,
	output wire [3:0] device_id,
	input wire cd_n_in,
	output wire cd_n_out,
	output wire cd_n_oe_n,
	input wire io_n_in,
	output wire io_n_out,
	output wire io_n_oe_n,
	input wire msg_n_in,
	output wire msg_n_out,
	output wire msg_n_oe_n,
	input wire req_n_in,
	output wire req_n_out,
	output wire req_n_oe_n,
	input wire ack_n_in,
	output wire ack_n_out,
	output wire ack_n_oe_n,
	input wire bus_rst_n_in,
	output wire bus_rst_n_out,
	output wire bus_rst_n_oe_n,
	input wire sel_n_in,
	output wire sel_n_out,
	output wire sel_n_oe_n,
	input wire bsy_n_in,
	output wire bsy_n_out,
	output wire bsy_n_oe_n,
	input wire atn_n_in,
	output wire atn_n_out,
	output wire atn_n_oe_n,
	output wire [3:0] diff_ctl_data_bus,
	output wire diff_ctl_data_oe_n,
	output wire [1:0] diff_ctl_latch_select,
	output wire diff_ctl_select_oe_n,
	output wire diff_ctl_latch_strobe_n,
	output wire diff_ctl_strobe_oe_n,
	output wire activity_indicator_n,
	output wire activity_indicator_oe_n,
	input wire ext_id_serial_in,
	input wire ram_present_n,
	output wire term_power_ctl,
	output wire term_power_ctl_oe_n,
	input wire wide_cable_present_n
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam [1:0] DF_IDLE = 2'h0;
	localparam [1:0] DF_SETUP = 2'h1;
	localparam [1:0] DF_STROBE = 2'h2;
	localparam [1:0] DF_HOLD = 2'h3;

	reg drive_q;
	reg shifting_q;
	reg lclk_q;
	reg [7:0] half_cnt_q;
	reg [3:0] edge_cnt_q;
	reg [3:0] id_q;
	reg mem_port_single_user_q;
	reg run_led_q;
	reg activity_q;
	reg led_diag_en_q;
	reg led_diag_val_q;
	reg term_power_polarity_q;
	reg term_power_on_q;
	reg [9:0] ctl_q;
	reg reset_seen_q;
	reg [1:0] df_state_q;
	reg [7:0] df_cnt_q;
	reg [3:0] diff_data_q;
	reg [1:0] diff_sel_q;
	reg rd_ack_q;

	wire target = ctl_q[`CT_TARGET];
	wire bus_free = bsy_n_in & sel_n_in;
	wire bus_reset_in = ~bus_rst_n_in;
	wire df_busy = (df_state_q != DF_IDLE);
	wire hit_diff = (avs_address == `OFS_DIFF_CONTROL);
	wire stall = shifting_q | (avs_write & hit_diff & df_busy);
	wire wr_go = avs_write & ~stall;
	wire rd_go = avs_read & ~stall & ~rd_ack_q;
	wire lo_en = avs_byteenable[0];
	wire hi_en = avs_byteenable[1];
	wire wr_bc = wr_go & lo_en & (avs_address == `OFS_BLOCK_CONTROL);
	wire wr_dc = wr_go & (avs_address == `OFS_DEVICE_CONFIG);
	wire wr_xc = wr_go & lo_en & (avs_address == `OFS_XFER_CONTROL_ONE);
	wire wr_ct = wr_go & (avs_address == `OFS_BUS_CONTROL);
	wire wr_st = wr_go & hi_en & (avs_address == `OFS_BUS_STATUS);
	wire wr_df = wr_go & lo_en & hit_diff;
	wire soft_reset = wr_dc & hi_en & avs_writedata[`DC_SOFT_RESET];
	wire sel_flags = selection_in_progress | selected_in_flag |
		selection_out_done;

	// Retry: stall the bus while shift-in runs
	// retry during shift
	assign avs_waitrequest = stall | (avs_read & ~rd_ack_q);

	// ------------------------------------------------------------
	// SCSI control lines (open drain, asserted low)
	// ------------------------------------------------------------
	// direction line role
	assign cd_n_out = 1'b0;
	assign io_n_out = 1'b0;
	assign msg_n_out = 1'b0;
	assign cd_n_oe_n = ~(drive_q & target & ctl_q[`CT_CD]);
	assign io_n_oe_n = ~(drive_q & target & ctl_q[`CT_IO]);
	assign msg_n_oe_n = ~(drive_q & target & ctl_q[`CT_MSG]);
	assign req_n_out = 1'b0;
	assign req_n_oe_n = ~(drive_q & target & ctl_q[`CT_REQ]);
	assign ack_n_out = 1'b0;
	assign ack_n_oe_n = ~(drive_q & ~target & ctl_q[`CT_ACK]);
	assign bus_rst_n_out = 1'b0;
	assign bus_rst_n_oe_n = ~(drive_q & ctl_q[`CT_BUS_RST]);
	assign sel_n_out = 1'b0;
	assign sel_n_oe_n = ~(drive_q & ctl_q[`CT_WON]);
	assign bsy_n_out = 1'b0;
	assign bsy_n_oe_n = ~(drive_q & (ctl_q[`CT_ARB] |
		(target & ctl_q[`CT_WON])));
	assign atn_n_out = 1'b0;
	assign atn_n_oe_n = ~(drive_q & ~target & ctl_q[`CT_ATN]);

	// ------------------------------------------------------------
	// Differential latch port
	// ------------------------------------------------------------
	// float during host reset
	assign diff_ctl_data_oe_n = ~drive_q;
	assign diff_ctl_select_oe_n = ~drive_q;
	assign diff_ctl_strobe_oe_n = ~drive_q;
	assign diff_ctl_data_bus = diff_data_q;
	assign diff_ctl_latch_select = diff_sel_q;
	assign diff_ctl_latch_strobe_n = ~(df_state_q == DF_STROBE);

	// ------------------------------------------------------------
	// Indicator and termination power
	// ------------------------------------------------------------
	// diagnostic override
	assign activity_indicator_n = shifting_q ? lclk_q :
		led_diag_en_q ? ~led_diag_val_q : ~(run_led_q | activity_q);
	assign activity_indicator_oe_n = ~drive_q;
	assign term_power_ctl = term_power_on_q ? term_power_polarity_q :
		~term_power_polarity_q;
	assign term_power_ctl_oe_n = ~drive_q;
	assign device_id = id_q;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_q <= 1'b0;
		end else begin
			drive_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// ID shift-in after host reset
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			shifting_q <= 1'b1;
			lclk_q <= 1'b0;
			half_cnt_q <= 8'h00;
			edge_cnt_q <= 4'h0;
			id_q <= `RST_DEFAULT_ID;
			mem_port_single_user_q <= 1'b0;
			run_led_q <= 1'b0;
		end else if (shifting_q) begin
			if (half_cnt_q == ID_HALF[7:0] - 8'h01) begin
				half_cnt_q <= 8'h00;
				lclk_q <= ~lclk_q;
				if (!lclk_q) begin
					id_q <= {id_q[2:0], ext_id_serial_in};
					edge_cnt_q <= edge_cnt_q + 4'h1;
					if (edge_cnt_q == `RAM_SAMPLE_EDGE - 4'h1)
						mem_port_single_user_q <= ~ram_present_n;
				end else if (edge_cnt_q == ID_BITS[3:0]) begin
					shifting_q <= 1'b0;
					run_led_q <= 1'b1;
				end
			end else begin
				half_cnt_q <= half_cnt_q + 8'h01;
			end
		end else if (wr_bc && avs_writedata[`BC_RUN_LED_CLR]) begin
			run_led_q <= 1'b0;
		end
	end

	// latch activity, clear at bus free
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			activity_q <= 1'b0;
		end else if (sel_flags) begin
			activity_q <= 1'b1;
		end else if (bus_free) begin
			activity_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			led_diag_en_q <= 1'b0;
			led_diag_val_q <= 1'b0;
			term_power_polarity_q <= 1'b0;
			term_power_on_q <= 1'b0;
			ctl_q <= `RST_CONTROL;
			reset_seen_q <= 1'b0;
			scsi_reset_clear <= 1'b0;
		end else begin
			scsi_reset_clear <= bus_reset_in;
			if (wr_bc) begin
				led_diag_en_q <= avs_writedata[`BC_LED_DIAG_EN];
				led_diag_val_q <= avs_writedata[`BC_LED_DIAG_VAL];
			end
			if (wr_dc && lo_en)
				term_power_polarity_q <= avs_writedata[`DC_TERM_POLARITY];
			if (soft_reset)
				term_power_on_q <= 1'b0;
			else if (wr_xc)
				term_power_on_q <= avs_writedata[`XC_TERM_ON];
			if (bus_reset_in || soft_reset) begin
				ctl_q <= {5'h00, ctl_q[`CT_BUS_RST], 3'h0,
					ctl_q[`CT_TARGET]};
				// Software can still drop its own bus reset drive
				if (wr_ct && lo_en) begin
					ctl_q[`CT_BUS_RST] <= avs_writedata[`CT_BUS_RST];
					ctl_q[`CT_TARGET] <= avs_writedata[`CT_TARGET];
				end
			end else if (wr_ct) begin
				if (lo_en)
					ctl_q[7:0] <= avs_writedata[7:0];
				if (hi_en)
					ctl_q[9:8] <= avs_writedata[9:8];
			end
			// Set wins over software clear
			if (bus_reset_in)
				reset_seen_q <= 1'b1;
			else if (wr_st && avs_writedata[`ST_RESET_SEEN])
				reset_seen_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Differential latch sequencer
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			df_state_q <= DF_IDLE;
			df_cnt_q <= 8'h00;
			diff_data_q <= 4'h0;
			diff_sel_q <= 2'h0;
		end else begin
			case (df_state_q)
			DF_IDLE: begin
				if (wr_df) begin
					diff_data_q <= avs_writedata[3:0];
					diff_sel_q <= avs_writedata[`DF_SEL_LSB+1:`DF_SEL_LSB];
					df_state_q <= DF_SETUP;
				end
			end
			DF_SETUP: begin
				df_cnt_q <= 8'h00;
				df_state_q <= DF_STROBE;
			end
			DF_STROBE: begin
				if (df_cnt_q == STROBE_CYCLES[7:0] - 8'h01)
					df_state_q <= DF_HOLD;
				else
					df_cnt_q <= df_cnt_q + 8'h01;
			end
			default: begin
				df_state_q <= DF_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ack_q <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			rd_ack_q <= rd_go;
			if (rd_go) begin
				if (avs_address == `OFS_BLOCK_CONTROL) begin
					avs_readdata <= {27'h0, run_led_q, ~wide_cable_present_n,
						1'b0, led_diag_val_q, led_diag_en_q};
				end else if (avs_address == `OFS_DEVICE_CONFIG) begin
					avs_readdata <= {20'h0, id_q, 6'h0,
						mem_port_single_user_q, term_power_polarity_q};
				end else if (avs_address == `OFS_XFER_CONTROL_ONE) begin
					avs_readdata <= {31'h0, term_power_on_q};
				end else if (avs_address == `OFS_BUS_CONTROL) begin
					avs_readdata <= {22'h0, ctl_q};
				end else if (avs_address == `OFS_BUS_STATUS) begin
					avs_readdata <= {20'h0, shifting_q, activity_q,
						reset_seen_q, ~atn_n_in, ~bsy_n_in, ~sel_n_in,
						bus_reset_in, ~ack_n_in, ~req_n_in, ~msg_n_in,
						~io_n_in, ~cd_n_in};
				end else if (hit_diff) begin
					avs_readdata <= {23'h0, df_busy, 2'h0, diff_sel_q,
						diff_data_q};
				end else begin
					avs_readdata <= 32'h00000000;
				end
			end
		end
	end

endmodule // scsi_bus_sideband_pin_control

`default_nettype wire

/* sideband_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sideband_asserts #(
	parameter STROBE_CYCLES = 10
) (
	input wire core_clk,
	input wire rst_b,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire scsi_reset_clear,
	input wire bus_rst_n_in,
	input wire cd_n_oe_n,
	input wire req_n_oe_n,
	input wire ack_n_oe_n,
	input wire atn_n_oe_n,
	input wire [3:0] diff_ctl_data_bus,
	input wire [1:0] diff_ctl_latch_select,
	input wire diff_ctl_latch_strobe_n,
	input wire diff_ctl_data_oe_n,
	input wire activity_indicator_n,
	input wire term_power_ctl_oe_n
);
	// ----
	// Cycles since reset and strobe low width
	// ----
	reg [7:0] cyc_q;
	reg [7:0] low_q;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cyc_q <= 8'h00;
			low_q <= 8'h00;
		end else begin
			cyc_q <= (cyc_q == 8'hFF) ? cyc_q : cyc_q + 8'h01;
			low_q <= diff_ctl_latch_strobe_n ? 8'h00 : low_q + 8'h01;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_id_low;
		!activity_indicator_n [*5] ##1 activity_indicator_n;
	endsequence
	sequence s_strobe_rise;
		$rose(diff_ctl_latch_strobe_n);
	endsequence
	AST_STROBE_LEN: assert property (s_strobe_rise |-> low_q == STROBE_CYCLES)
		else $error("strobe width wrong");
	AST_STROBE_HOLD: assert property (!$past(diff_ctl_latch_strobe_n) |->
		$stable(diff_ctl_data_bus) && $stable(diff_ctl_latch_select))
		else $error("latch data moved under strobe");
	AST_REQ_ACK: assert property (!req_n_oe_n |-> ack_n_oe_n)
		else $error("request and acknowledge both driven");
	AST_PHASE_ATN: assert property (!cd_n_oe_n |-> atn_n_oe_n)
		else $error("phase and attention both driven");
	AST_BUS_RST: assert property ($fell(bus_rst_n_in) |-> ##[1:2] scsi_reset_clear)
		else $error("bus reset not seen");
	AST_ID_CLK: assert property ($fell(activity_indicator_n) && cyc_q > 8'h01 &&
		cyc_q < 8'h1E |-> s_id_low)
		else $error("ID clock half period wrong");
	AST_RETRY: assert property ((avs_read || avs_write) && cyc_q < 8'h1E |->
		avs_waitrequest)
		else $error("access accepted during ID shift");
	AST_DRIVE_RUN: assert property (cyc_q > 8'h01 |->
		!diff_ctl_data_oe_n && !term_power_ctl_oe_n)
		else $error("output floating after reset");
	AST_RUN_LED: assert property (cyc_q == 8'h3C |-> !activity_indicator_n)
		else $error("run indicator not held");
endmodule // sideband_asserts
`default_nettype wire

/* sideband_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module sideband_partner (
	input wire core_clk,
	input wire rst_b,
	input wire [3:0] id_value,
	input wire activity_indicator_n,
	input wire [3:0] diff_ctl_data_bus,
	input wire [1:0] diff_ctl_latch_select,
	input wire diff_ctl_latch_strobe_n,
	input wire reset_req,
	output logic ext_id_serial_in,
	output logic bus_rst_drv_n,
	output logic [15:0] latch_q
);
	int idx;
	always @(posedge activity_indicator_n or negedge rst_b) begin
		if (!rst_b)
			idx <= 3;
		else
			idx <= idx - 1;
	end
	always @(negedge activity_indicator_n or negedge rst_b) begin
		if (!rst_b)
			ext_id_serial_in <= id_value[3];
		else
			ext_id_serial_in <= (idx >= 0) ? id_value[idx] : ~ext_id_serial_in;
	end
	always @(posedge diff_ctl_latch_strobe_n) begin
		latch_q[{diff_ctl_latch_select, 2'b00} +: 4] <= diff_ctl_data_bus;
	end
	// lines released, reset only on command
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			bus_rst_drv_n <= 1'b1;
		else
			bus_rst_drv_n <= ~reset_req;
	end
endmodule // sideband_partner
`default_nettype wire

/* tb_scsi_bus_sideband_pin_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scsi_sideband_defines.vh"
module tb_scsi_bus_sideband_pin_control;
	logic core_clk, rst_b, avs_read, avs_write, reset_req;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, rdat, c;
	logic [3:0] avs_byteenable, id_value;
	logic selection_in_progress, selected_in_flag, selection_out_done;
	logic ram_present_n, wide_cable_present_n;
	wire [31:0] avs_readdata;
	wire [3:0] device_id, diff_ctl_data_bus;
	wire [1:0] diff_ctl_latch_select;
	wire [15:0] latch_q;
	wire avs_waitrequest, cd_n_oe_n, io_n_oe_n, msg_n_oe_n, req_n_oe_n;
	wire ack_n_oe_n, bus_rst_n_oe_n, sel_n_oe_n, bsy_n_oe_n, atn_n_oe_n;
	wire diff_ctl_data_oe_n, diff_ctl_select_oe_n, diff_ctl_latch_strobe_n;
	wire diff_ctl_strobe_oe_n, activity_indicator_n, activity_indicator_oe_n;
	wire ext_id_serial_in, term_power_ctl, term_power_ctl_oe_n, bus_rst_drv_n;
	int error_cnt, n_compared, seed, wait_n, rises, i;
	int exp_q[$];
	scsi_bus_sideband_pin_control scsi_bus_sideband_pin_control_inst (
		.core_clk, .rst_b, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.selection_in_progress, .selected_in_flag, .selection_out_done,
		.scsi_reset_clear(), .device_id,
		.cd_n_in(cd_n_oe_n), .cd_n_out(), .cd_n_oe_n,
		.io_n_in(io_n_oe_n), .io_n_out(), .io_n_oe_n,
		.msg_n_in(msg_n_oe_n), .msg_n_out(), .msg_n_oe_n,
		.req_n_in(req_n_oe_n), .req_n_out(), .req_n_oe_n,
		.ack_n_in(ack_n_oe_n), .ack_n_out(), .ack_n_oe_n,
		.bus_rst_n_in(bus_rst_n_oe_n & bus_rst_drv_n), .bus_rst_n_out(),
		.bus_rst_n_oe_n, .sel_n_in(sel_n_oe_n), .sel_n_out(), .sel_n_oe_n,
		.bsy_n_in(bsy_n_oe_n), .bsy_n_out(), .bsy_n_oe_n,
		.atn_n_in(atn_n_oe_n), .atn_n_out(), .atn_n_oe_n,
		.diff_ctl_data_bus, .diff_ctl_data_oe_n, .diff_ctl_latch_select,
		.diff_ctl_select_oe_n, .diff_ctl_latch_strobe_n, .diff_ctl_strobe_oe_n,
		.activity_indicator_n, .activity_indicator_oe_n, .ext_id_serial_in,
		.ram_present_n, .term_power_ctl, .term_power_ctl_oe_n,
		.wide_cable_present_n
	);
	sideband_partner sideband_partner_inst (
		.core_clk, .rst_b, .id_value, .activity_indicator_n,
		.diff_ctl_data_bus, .diff_ctl_latch_select, .diff_ctl_latch_strobe_n,
		.reset_req, .ext_id_serial_in, .bus_rst_drv_n, .latch_q
	);
	task automatic chk(input [31:0] seen, input [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input rd, input [4:0] a, input [31:0] d);
		int n;
		@(posedge core_clk);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= {2'($random(seed)), 2'b11};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest && n < 400);
		if (n >= 400)
			error_cnt++;
		rdat = avs_readdata;
		wait_n = n;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(negedge core_clk);
	endtask
	task automatic close_out;
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// RAM-present level seen at the fourth ID rise only
	always @(posedge activity_indicator_n) begin
		rises++;
		if (rises == 3 || rises == 4)
			ram_present_n <= !ram_present_n;
	end
	// Run needs under 1500 cycles
	initial begin
		#20000;
		error_cnt++;
		close_out;
	end
	initial begin
		seed = 39772;
		rst_b = 1'b1;
		{avs_read, avs_write, reset_req, avs_address} = 8'h00;
		{selection_in_progress, selected_in_flag, selection_out_done} = 3'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h3;
		wide_cable_present_n = 1'b1;
		id_value = 4'($random(seed));
		ram_present_n = 1'($random(seed));
		#1 rst_b = 1'b0;
		repeat (5) @(posedge core_clk);
		chk({diff_ctl_data_oe_n, diff_ctl_select_oe_n, diff_ctl_strobe_oe_n,
			diff_ctl_latch_strobe_n, term_power_ctl_oe_n}, 5'h1F);
		chk(activity_indicator_oe_n, 1);
		rises = 0;
		rst_b <= 1'b1;
		bus(1, `OFS_DEVICE_CONFIG, 0);
		chk(wait_n > 30, 1);
		// Fourth rise saw the inverse of the level now standing
		chk(rdat[15:0], {4'h0, id_value, 6'h00, ram_present_n, 1'b0});
		chk(device_id, id_value);
		chk({diff_ctl_data_oe_n, diff_ctl_select_oe_n, diff_ctl_strobe_oe_n,
			activity_indicator_oe_n, term_power_ctl_oe_n}, 5'h00);
		chk(rises, 4);
		repeat (30) @(negedge core_clk);
		chk(activity_indicator_n, 0);
		bus(0, `OFS_BLOCK_CONTROL, 32'h4);
		chk(activity_indicator_n, 1);
		for (i = 0; i < 2; i++) begin
			bus(0, `OFS_BLOCK_CONTROL, 1 + 2 * i);
			chk(activity_indicator_n, !i);
		end
		bus(0, `OFS_BLOCK_CONTROL, 0);
		for (i = 0; i < 3; i++) begin
			bus(0, `OFS_BUS_CONTROL, 32'h2);
			@(posedge core_clk);
			{selection_in_progress, selected_in_flag, selection_out_done} <= 3'h1 << i;
			@(posedge core_clk);
			{selection_in_progress, selected_in_flag, selection_out_done} <= 3'h0;
			repeat (3) @(negedge core_clk);
			chk(activity_indicator_n, 0);
			bus(0, `OFS_BUS_CONTROL, 0);
			repeat (2) @(negedge core_clk);
			chk(activity_indicator_n, 1);
		end
		for (i = 0; i < 4; i++) begin
			bus(0, `OFS_DEVICE_CONFIG, i & 1);
			bus(0, `OFS_XFER_CONTROL_ONE, i >> 1);
			chk(term_power_ctl, (i >> 1) ? (i & 1) : !(i & 1));
		end
		bus(0, `OFS_DEVICE_CONFIG, 32'h8001);
		bus(1, `OFS_XFER_CONTROL_ONE, 0);
		chk({rdat[0], term_power_ctl}, 2'b00);
		for (i = 0; i < 2; i++) begin
			@(posedge core_clk);
			wide_cable_present_n <= i[0];
			bus(1, `OFS_BLOCK_CONTROL, 0);
			chk(rdat[3], !i);
		end
		for (i = 0; i < 16; i++) begin
			c = $random(seed) & 32'h3EF;
			bus(0, `OFS_BUS_CONTROL, c);
			chk({cd_n_oe_n, io_n_oe_n, msg_n_oe_n, req_n_oe_n},
				{~({4{c[0]}} & {c[5], c[6], c[7], c[8]})});
			chk({ack_n_oe_n, atn_n_oe_n}, {~({2{!c[0]}} & {c[9], c[3]})});
			chk({sel_n_oe_n, bsy_n_oe_n}, {~{c[2], c[1] | (c[0] & c[2])}});
		end
		bus(0, `OFS_BUS_CONTROL, 32'h3E5);
		@(posedge core_clk);
		reset_req <= 1'b1;
		@(posedge core_clk);
		reset_req <= 1'b0;
		repeat (4) @(negedge core_clk);
		bus(1, `OFS_BUS_CONTROL, 0);
		chk(rdat[9:0], 10'h001);
		bus(0, `OFS_BUS_CONTROL, 32'h3F5);
		bus(1, `OFS_BUS_CONTROL, 0);
		chk(rdat[9:0], 10'h011);
		bus(0, `OFS_BUS_CONTROL, 0);
		bus(1, `OFS_BUS_CONTROL, 0);
		chk(rdat[9:0], 10'h000);
		for (i = 0; i < 4; i++) begin
			c = $random(seed) & 32'hF;
			exp_q.push_back(c);
			bus(0, `OFS_DIFF_CONTROL, c | (i << 4));
		end
		repeat (20) @(negedge core_clk);
		for (i = 0; i < 4; i++)
			chk(latch_q[i * 4 +: 4], exp_q.pop_front());
		bus(1, 5'h1C, 0);
		chk(rdat, 0);
		close_out;
	end
endmodule // tb_scsi_bus_sideband_pin_control
bind scsi_bus_sideband_pin_control sideband_asserts #(
	.STROBE_CYCLES(STROBE_CYCLES)
) sideband_asserts_inst (
	.core_clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest,
	.scsi_reset_clear, .bus_rst_n_in, .cd_n_oe_n, .req_n_oe_n, .ack_n_oe_n,
	.atn_n_oe_n, .diff_ctl_data_bus, .diff_ctl_latch_select,
	.diff_ctl_latch_strobe_n, .diff_ctl_data_oe_n, .activity_indicator_n,
	.term_power_ctl_oe_n
);
`default_nettype wire
